// file: desc_defines.vh
// descriptor field positions, codes and constants
`ifndef DESC_DEFINES_VH
`define DESC_DEFINES_VH
`define DUR_LSB        0
`define DUR_MSB        14
`define DUR_UPD_BIT    15
`define TRIES0_LSB     16
`define RATE_W         5
`define RATE0_LSB      0
`define PROT_RATE_LSB  20
`define RX_MORE_BIT    12
`define RX_RATE_LSB    15
`define RX_SIG_LSB     20
`define RX_ANT_LSB     28
`define ST_DONE_BIT    0
`define ST_OK_BIT      1
`define ST_CRC_BIT     2
`define ST_DCRC_BIT    3
`define ST_PHY_BIT     4
`define ST_MIC_BIT     5
`define ST_KEYV_BIT    8
`define ST_KEYI_LSB    9
`define RATE_RSVD      4'h0
`define WORD_W         32
`endif

// file: status_buffer.v
// two-entry valid/ready buffer for status write-back words
`timescale 1ns/1ps
`default_nettype none
module status_buffer #(
  parameter WIDTH = 64,
  parameter DEPTH = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0]       count;
  reg             wr_ptr;
  reg             rd_ptr;
  wire            push;
  wire            pop;
  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      count  <= 2'd0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // read data registered: show head word (next head when popping)
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      out_data <= {WIDTH{1'b0}};
    end else if (pop && count == 2'd2) begin
      out_data <= mem[~rd_ptr];
    end else if (push && (count == 2'd0 || (pop && count == 2'd1))) begin
      out_data <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: wlan_dma_descriptor_fields.v
// descriptor field decode and receive status write-back
// What this block does
// - protect frame duration comes from word 4 bits 14:0 into RTS or CTS
// - bit 15 enables rewriting frame duration at current rate, not RTS/CTS
// - series 1..3 counts from word 4 nibbles, zero count skips series
// - only attempts putting the frame on air consume the try limit
// - series 0..3 rate codes from word 5 five-bit fields, low upward
// - OFDM codes 0b,0f,0a,0e,09,0d,08,0c decode 6..54 Mbps, doubled turbo
// - CCK codes 1b,1a,1e,19,1d,18,1c decode; all others reserved
// - RTS/CTS sent at rate code in word 5 bits 24:20
// - raise descriptor interrupt at frame end when request flag set
// - status word 4 low 12 bits give bytes stored per descriptor
// - bit 12 set when frame continues, clear on last descriptor
// - final descriptor reports received rate in bits 19:15 unless a PHY error failed it
// - final descriptor reports signal level in bits 27:20 on success
// - final descriptor reports receive antenna in top nibble always
// - done bit set only in final descriptor after all status updated
// - success bit 1; failures set bit 2 crc, bit 3 decrypt crc
// - PHY error sets bit 4, code bit0 in bit 8, bits 4:1 from bit 9
// - Michael error bit 5 only final, failed, TKIP, unfragmented, no decrypt error
// - on success bit 8 key hit, key index from bit 9
// - host loads list head and writes transmit enable after appending
`timescale 1ns/1ps
`default_nettype none
`include "desc_defines.vh"
module wlan_dma_descriptor_fields #(
  parameter LEN_W = 12
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  // transmit descriptor words 4 and 5
  input  wire [31:0]      tx_word4,
  input  wire [31:0]      tx_word5,
  input  wire             tx_load,
  input  wire             rts_protect_enable,
  input  wire             cts_protect_enable,
  input  wire             turbo_mode,
  // transmit attempt feedback from protocol control unit
  input  wire             attempt_done,
  input  wire             attempt_frame_on_air,
  // decoded transmit controls
  output reg  [14:0]      protect_frame_duration,
  output reg              protect_duration_valid,
  output reg  [4:0]       protect_frame_rate_code,
  output reg              duration_rewrite_enable,
  output reg  [1:0]       active_series,
  output reg  [4:0]       active_rate_code,
  output reg  [9:0]       active_rate_halfmbps,
  output reg              active_rate_cck,
  output reg              active_rate_reserved,
  output reg              tx_series_exhausted,
  // receive descriptor control
  input  wire             completion_irq_request,
  // receive events from receive_dma_unit path, one pulse per descriptor
  input  wire             rx_desc_end,
  input  wire             rx_frame_last,
  input  wire [LEN_W-1:0] received_byte_count,
  input  wire [4:0]       received_rate_code,
  input  wire [7:0]       received_signal_level,
  input  wire [3:0]       received_antenna_select,
  input  wire             reception_success_flag,
  input  wire             frame_check_error,
  input  wire             decrypt_check_error,
  input  wire             physical_layer_error,
  input  wire [4:0]       physical_error_code,
  input  wire             tkip_integrity_error,
  input  wire             frame_is_tkip,
  input  wire             frame_is_fragment,
  input  wire             key_lookup_hit,
  input  wire [6:0]       key_table_index,
  output wire             rx_ready,
  // status write-back toward host memory
  output wire             status_valid,
  input  wire             status_ready,
  output wire [31:0]      status_word4,
  output wire [31:0]      status_word5,
  output reg              desc_irq
);
  // turbo doubles OFDM rates only, not CCK; result in half-Mbps units
  function [9:0] rate_decode;
    input [4:0] code;
    input       turbo;
    reg   [9:0] r;
    begin
      case (code)
        5'h0b: r = 10'd12;
        5'h0f: r = 10'd18;
        5'h0a: r = 10'd24;
        5'h0e: r = 10'd36;
        5'h09: r = 10'd48;
        5'h0d: r = 10'd72;
        5'h08: r = 10'd96;
        5'h0c: r = 10'd108;
        5'h1b: r = 10'd2;
        5'h1a: r = 10'd4;
        5'h1e: r = 10'd4;
        5'h19: r = 10'd11;
        5'h1d: r = 10'd11;
        5'h18: r = 10'd22;
        5'h1c: r = 10'd22;
        default: r = 10'd0;
      endcase
      rate_decode = (turbo && code[4] == 1'b0) ? {r[8:0], 1'b0} : r;
    end
  endfunction

  reg [3:0]  tries [0:3];
  reg [4:0]  rates [0:3];
  reg [3:0]  used;
  reg [1:0]  next_series;
  reg        next_found;
  wire       active;
  integer    i;
  integer    j;
  wire       is_cck;
  wire [9:0] dec;

  assign dec    = rate_decode(active_rate_code, turbo_mode);
  assign is_cck = active_rate_code[4];

  // pick first series after current with nonzero count
  always @* begin
    next_series = active_series;
    next_found  = 1'b0;
    for (j = 3; j > 0; j = j - 1) begin
      if (j > active_series && tries[j] != 4'h0) begin
        next_series = j[1:0];
        next_found  = 1'b1;
      end
    end
  end

  // one-hot series walk: idle, running, or every series ran dry
  localparam [2:0] TX_IDLE  = 3'b001;
  localparam [2:0] TX_RUN   = 3'b010;
  localparam [2:0] TX_SPENT = 3'b100;
  reg  [2:0] tx_state;
  reg  [2:0] next_tx_state;
  wire       on_air;
  wire       series_spent;
  assign active       = (tx_state == TX_RUN);
  // an RTS without CTS never qualifies as an attempt
  assign on_air       = attempt_done && attempt_frame_on_air;
  // a zero series 0 count is a host fault; it then ends after one attempt
  assign series_spent = (used + 4'h1 >= tries[active_series]);

  always @* begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (tx_load) begin
          next_tx_state = TX_RUN;
        end
      end
      TX_RUN: begin
        // a fresh descriptor wins over a late attempt of the old one
        if (!tx_load && on_air && series_spent && !next_found) begin
          next_tx_state = TX_SPENT;
        end
      end
      TX_SPENT: begin
        if (tx_load) begin
          next_tx_state = TX_RUN;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      protect_frame_duration  <= 15'h0000;
      protect_duration_valid  <= 1'b0;
      protect_frame_rate_code <= 5'h00;
      duration_rewrite_enable <= 1'b0;
      active_series           <= 2'h0;
      used                    <= 4'h0;
      tx_series_exhausted     <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        tries[i] <= 4'h0;
        rates[i] <= 5'h00;
      end
    end else if (tx_load) begin
      // load strobe carries the host's transmit-enable notice
      // word 5 bits 31:25 are reserved and never looked at
      protect_frame_duration  <= tx_word4[`DUR_MSB:`DUR_LSB];
      protect_duration_valid  <= rts_protect_enable | cts_protect_enable;
      duration_rewrite_enable <= tx_word4[`DUR_UPD_BIT];
      protect_frame_rate_code <= tx_word5[`PROT_RATE_LSB +: `RATE_W];
      for (i = 0; i < 4; i = i + 1) begin
        tries[i] <= tx_word4[`TRIES0_LSB + 4*i +: 4];
        rates[i] <= tx_word5[`RATE0_LSB + `RATE_W*i +: `RATE_W];
      end
      active_series       <= 2'h0;   // series 0 nonzero by host contract
      used                <= 4'h0;
      tx_series_exhausted <= 1'b0;
    end else if (active && on_air) begin
      // failed RTS never reaches here, so it costs no attempt
      if (series_spent) begin
        used <= 4'h0;
        if (next_found) begin
          active_series <= next_series;
        end else begin
          tx_series_exhausted <= 1'b1;
        end
      end else begin
        used <= used + 4'h1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      active_rate_code     <= 5'h00;
      active_rate_halfmbps <= 10'd0;
      active_rate_cck      <= 1'b0;
      active_rate_reserved <= 1'b0;
    end else begin
      active_rate_code     <= rates[active_series];
      active_rate_halfmbps <= dec;
      active_rate_cck      <= is_cck && dec != 10'd0;
      active_rate_reserved <= (dec == 10'd0);
    end
  end

  // receive status assembly
  reg  [31:0] w4;
  reg  [31:0] w5;
  wire        phy_fail;
  assign phy_fail = !reception_success_flag && physical_layer_error;

  always @* begin
    w4 = 32'h0000_0000;
    w5 = 32'h0000_0000;   // bits 7:6 stay zero
    w4[LEN_W-1:0]     = received_byte_count;
    w4[`RX_MORE_BIT]  = !rx_frame_last;
    if (rx_frame_last) begin
      if (!phy_fail) begin
        w4[`RX_RATE_LSB +: 5] = received_rate_code;
      end
      if (reception_success_flag) begin
        w4[`RX_SIG_LSB +: 8]  = received_signal_level;
        w5[`ST_KEYV_BIT]      = key_lookup_hit;
        w5[`ST_KEYI_LSB +: 7] = key_table_index;
      end else begin
        w5[`ST_CRC_BIT]  = frame_check_error;
        w5[`ST_DCRC_BIT] = decrypt_check_error;
        w5[`ST_MIC_BIT]  = tkip_integrity_error && frame_is_tkip &&
                           !frame_is_fragment && !decrypt_check_error;
        if (physical_layer_error) begin
          w5[`ST_PHY_BIT]       = 1'b1;
          w5[`ST_KEYV_BIT]      = physical_error_code[0];
          w5[`ST_KEYI_LSB +: 7] = {3'b000, physical_error_code[4:1]};
        end
      end
      w4[`RX_ANT_LSB +: 4] = received_antenna_select;
      w5[`ST_OK_BIT]       = reception_success_flag;
      // done travels in the same buffer entry as every other status bit
      w5[`ST_DONE_BIT]     = 1'b1;
    end
  end

  wire        buf_in_ready;
  wire [63:0] buf_out;
  assign rx_ready = buf_in_ready;

  status_buffer #(
    .WIDTH (64),
    .DEPTH (2)
  ) u_status_buffer (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (rx_desc_end),
    .in_ready  (buf_in_ready),
    .in_data   ({w5, w4}),
    .out_valid (status_valid),
    .out_ready (status_ready),
    .out_data  (buf_out)
  );
  assign status_word4 = buf_out[31:0];
  assign status_word5 = buf_out[63:32];

  // interrupt only once the final status has left the buffer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      desc_irq <= 1'b0;
    end else begin
      desc_irq <= status_valid && status_ready && buf_out[32 + `ST_DONE_BIT] &&
                  completion_irq_request;
    end
  end
endmodule
`default_nettype wire

// file: host_status_sink.sv
// host memory model taking status write-back entries
`timescale 1ns/1ps
`default_nettype none
module host_status_sink (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // bus stall request from the bench
  input  wire logic        stall,
  // status write-back
  input  wire logic        status_valid,
  output logic             status_ready,
  input  wire logic [31:0] status_word4,
  input  wire logic [31:0] status_word5,
  output logic [7:0]       pop_cnt
);
  logic [31:0] w4 [16];
  logic [31:0] w5 [16];
  // a slow host bus is modelled by holding ready low
  assign status_ready = !stall;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pop_cnt <= 8'h0;
    end else if (status_valid && status_ready) begin
      w4[pop_cnt[3:0]] <= status_word4;
      w5[pop_cnt[3:0]] <= status_word5;
      pop_cnt <= pop_cnt + 8'h1;
    end
  end
endmodule
`default_nettype wire

// file: desc_fields_assertions.sv
// assertion checker for descriptor decode and status write-back
`timescale 1ns/1ps
`default_nettype none
module desc_fields_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // transmit decode
  input wire logic [31:0] tx_word4,
  input wire logic [31:0] tx_word5,
  input wire logic        tx_load,
  input wire logic [14:0] protect_frame_duration,
  input wire logic [4:0]  protect_frame_rate_code,
  input wire logic        duration_rewrite_enable,
  // status write-back
  input wire logic        completion_irq_request,
  input wire logic        status_valid,
  input wire logic        status_ready,
  input wire logic [31:0] status_word4,
  input wire logic [31:0] status_word5,
  input wire logic        desc_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire pop_irq = status_valid && status_ready && status_word5[0] && completion_irq_request;
  a_dur_load: assert property (tx_load |=> protect_frame_duration == $past(tx_word4[14:0]))
    else $error("duration not taken");
  a_rewrite_flag: assert property (tx_load |=> duration_rewrite_enable == $past(tx_word4[15]))
    else $error("rewrite flag not taken");
  a_protect_rate: assert property (tx_load |=> protect_frame_rate_code == $past(tx_word5[24:20]))
    else $error("protect rate not taken");
  a_more_flag: assert property (status_valid |-> status_word4[12] != status_word5[0])
    else $error("more flag wrong");
  a_nonfinal_clean: assert property (status_valid && !status_word5[0] |-> status_word5 == 32'h0)
    else $error("status on non-final entry");
  a_reserved_zero: assert property (status_valid |-> status_word5[7:6] == 2'h0)
    else $error("reserved bits set");
  a_mic_exclusive: assert property (status_valid && status_word5[5] |-> !status_word5[3] && !status_word5[1])
    else $error("integrity flag misplaced");
  a_irq_follows: assert property (pop_irq |=> desc_irq)
    else $error("irq missing");
  a_irq_cause: assert property (desc_irq |-> $past(pop_irq))
    else $error("irq without cause");
  a_head_hold: assert property (status_valid && !status_ready |=> status_valid && $stable(status_word4) && $stable(status_word5))
    else $error("head entry changed");
  c_irq: cover property (desc_irq);
  c_stall: cover property (status_valid && !status_ready);
  c_phy: cover property (status_valid && status_word5[4]);
endmodule
bind wlan_dma_descriptor_fields desc_fields_checker u_chk (.clk_sys, .sys_rst, .tx_word4, .tx_word5, .tx_load,
  .protect_frame_duration, .protect_frame_rate_code, .duration_rewrite_enable, .completion_irq_request,
  .status_valid, .status_ready, .status_word4, .status_word5, .desc_irq);
`default_nettype wire

// file: tb_wlan_dma_descriptor_fields.sv
// testbench for descriptor decode and status write-back
`timescale 1ns/1ps
`default_nettype none
module tb_wlan_dma_descriptor_fields;
  logic        clk_sys = 0, sys_rst = 1, stall = 0, tx_load = 0, turbo_mode = 0;
  logic        rts_protect_enable = 1, cts_protect_enable = 0, attempt_done = 0, attempt_frame_on_air = 0;
  logic        completion_irq_request = 1, rx_desc_end = 0, rx_frame_last = 0, key_lookup_hit = 1;
  logic        reception_success_flag = 0, frame_check_error = 0, decrypt_check_error = 0;
  logic        physical_layer_error = 0, tkip_integrity_error = 0, frame_is_tkip = 0, frame_is_fragment = 0;
  logic [31:0] tx_word4 = 0, tx_word5 = 0;
  logic [11:0] received_byte_count = 0;
  logic [4:0]  received_rate_code = 5'h0c, physical_error_code = 0;
  logic [7:0]  received_signal_level = 8'h5a;
  logic [3:0]  received_antenna_select = 4'h3;
  logic [6:0]  key_table_index = 7'h2b;
  wire [14:0]  protect_frame_duration;
  wire         protect_duration_valid, duration_rewrite_enable, active_rate_cck, active_rate_reserved;
  wire         tx_series_exhausted, rx_ready, status_valid, status_ready, desc_irq;
  wire [4:0]   protect_frame_rate_code, active_rate_code;
  wire [1:0]   active_series;
  wire [9:0]   active_rate_halfmbps;
  wire [31:0]  status_word4, status_word5;
  wire [7:0]   pop_cnt;
  int          failures = 0, tests_run = 0, irqs = 0, n = 0, c = 0;
  logic [31:0] e4 [16], m4 [16], e5 [16], m5 [16];
  logic [4:0]  rc [17] = '{5'h0b, 5'h0f, 5'h0a, 5'h0e, 5'h09, 5'h0d, 5'h08, 5'h0c, 5'h1b, 5'h1a, 5'h1e,
                           5'h19, 5'h1d, 5'h18, 5'h1c, 5'h03, 5'h0c};
  int          hm [17] = '{12, 18, 24, 36, 48, 72, 96, 108, 2, 4, 4, 11, 11, 22, 22, 0, 216};
  wlan_dma_descriptor_fields #(.LEN_W(12)) DUT (.clk_sys, .sys_rst, .tx_word4, .tx_word5, .tx_load,
    .rts_protect_enable, .cts_protect_enable, .turbo_mode, .attempt_done, .attempt_frame_on_air,
    .protect_frame_duration, .protect_duration_valid, .protect_frame_rate_code, .duration_rewrite_enable,
    .active_series, .active_rate_code, .active_rate_halfmbps, .active_rate_cck, .active_rate_reserved,
    .tx_series_exhausted, .completion_irq_request, .rx_desc_end, .rx_frame_last, .received_byte_count,
    .received_rate_code, .received_signal_level, .received_antenna_select, .reception_success_flag,
    .frame_check_error, .decrypt_check_error, .physical_layer_error, .physical_error_code,
    .tkip_integrity_error, .frame_is_tkip, .frame_is_fragment, .key_lookup_hit, .key_table_index,
    .rx_ready, .status_valid, .status_ready, .status_word4, .status_word5, .desc_irq);
  host_status_sink host (.clk_sys, .sys_rst, .stall, .status_valid, .status_ready, .status_word4,
    .status_word5, .pop_cnt);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (desc_irq === 1'b1) irqs++;
  task tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [31:0] msk = 32'hffffffff);
    tests_run++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task load(input [31:0] w4, input [31:0] w5);
    tx_word4 = w4;
    tx_word5 = w5;
    tx_load = 1;
    tick(1);
    tx_load = 0;
    tick(3);
  endtask
  task attempt(input air);
    attempt_done = 1;
    attempt_frame_on_air = air;
    tick(1);
    attempt_done = 0;
    tick(2);
  endtask
  // f holds success, crc, decrypt crc and phy error, high to low
  task rx_desc(input [11:0] len, input last, input [3:0] f, input [4:0] cd);
    int k;
    k = 0;
    while (rx_ready !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    {reception_success_flag, frame_check_error, decrypt_check_error, physical_layer_error} = f;
    received_byte_count = len;
    rx_frame_last = last;
    physical_error_code = cd;
    rx_desc_end = 1;
    e4[n] = last ? {received_antenna_select, received_signal_level, received_rate_code, 3'h0, len}
                 : {19'h0, 1'b1, len};
    m4[n] = last ? {4'hf, {8{f[3]}}, {5{f[3] | !f[0]}}, 15'h7fff} : '1;
    e5[n] = last ? {16'h0, f[3] ? {key_table_index, key_lookup_hit} : {3'h0, cd}, 2'h0,
                    tkip_integrity_error & frame_is_tkip & !f[1] & !f[3], f[0], f[1], f[2], f[3], 1'b1} : '0;
    m5[n] = last ? {16'hffff, {8{f[3] | f[0]}}, 8'hff} : '1;
    n++;
    tick(1);
    rx_desc_end = 0;
    tick(1);
  endtask
  task drain;
    int k;
    k = 0;
    while (pop_cnt !== n[7:0] && k < 100) begin
      tick(1);
      k++;
    end
    tick(2);
    chk(pop_cnt, n);
    for (int i = c; i < n; i++) begin
      chk(host.w4[i], e4[i], m4[i]);
      chk(host.w5[i], e5[i], m5[i]);
    end
    c = n;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    tally_and_finish;
  end
  initial begin
    tick(20);
    sys_rst = 0;
    load(32'h0201_9234, 32'h01bc_2bcc);
    chk(protect_frame_duration, 15'h1234);
    chk(duration_rewrite_enable, 1);
    chk(protect_frame_rate_code, 5'h1b);
    chk(active_rate_halfmbps, 108);
    attempt(0);
    chk(active_series, 0);
    attempt(1);
    chk(active_series, 2);
    chk(active_rate_code, 5'h0a);
    attempt(1);
    chk(tx_series_exhausted, 0);
    attempt(1);
    chk(tx_series_exhausted, 1);
    rts_protect_enable = 0;
    for (int i = 0; i < 17; i++) begin
      turbo_mode = (i == 16);
      cts_protect_enable = i[0];
      load(32'h0001_0000, {27'h0, rc[i]});
      chk(active_rate_halfmbps, hm[i]);
      chk(protect_duration_valid, i[0]);
      chk(active_rate_cck, i >= 8 && i <= 14);
      chk(active_rate_reserved, i == 15);
      chk(duration_rewrite_enable, 0);
      chk(tx_series_exhausted, 0);
    end
    $display("test transmit decode done");
    rx_desc(12'h200, 0, 4'b1000, 0);
    rx_desc(12'h07c, 1, 4'b1000, 0);
    drain;
    chk(irqs, 1);
    completion_irq_request = 0;
    rx_desc(12'h010, 1, 4'b0001, 5'b00101);
    rx_desc(12'h010, 1, 4'b0001, 5'b11010);
    rx_desc(12'h020, 1, 4'b0100, 0);
    frame_is_tkip = 1;
    tkip_integrity_error = 1;
    rx_desc(12'h020, 1, 4'b0000, 0);
    rx_desc(12'h020, 1, 4'b0010, 0);
    drain;
    chk(irqs, 1);
    $display("test receive status done");
    stall = 1;
    rx_desc(12'h004, 0, 4'b1000, 0);
    rx_desc(12'h008, 1, 4'b1000, 0);
    tick(2);
    chk(rx_ready, 0);
    stall = 0;
    drain;
    $display("test stalled host done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
